// file: rtl/rfc_channel.sv
// one 16-bit timer channel with overflow tally and cumulative capture
// assumes count and capture strobes already on core_clk
`timescale 1ns/1ps
`default_nettype none
module rfc_channel
    import rfc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // strobes
    input wire logic count_en,
    input wire logic capture,
    // result
    output logic [RFC_CUM_W-1:0] cum_q
);
    logic [RFC_CNT_W-1:0] cnt_q;
    logic [RFC_OVF_W-1:0] ovf_q;
    logic counter_max_event;

    // the counter wraps to zero; the wrap is the max event
    assign counter_max_event = count_en && (cnt_q == RFC_CNT_MAX);

    // ************************************************************
    // counter and overflow tally
    // ************************************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= RFC_CNT_ZERO;
            ovf_q <= '0;
        end else if (count_en) begin
            cnt_q <= cnt_q + 16'h0001;
            if (counter_max_event) begin
                ovf_q <= ovf_q + 16'h0001;
            end
        end
    end

    // cumulative capture = raw + 65536 * tally, concatenation avoids a wide mul
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cum_q <= '0;
        end else if (capture) begin
            cum_q <= {ovf_q, cnt_q};
        end
    end

    property p_cum_capture;
        @(posedge core_clk) disable iff (!resetn)
        capture |=> cum_q == {$past(ovf_q), $past(cnt_q)};
    endproperty
    a_cum_capture: assert property (p_cum_capture)
        else $error("capture does not match tally and count");

    property p_wrap;
        @(posedge core_clk) disable iff (!resetn)
        counter_max_event |=> cnt_q == RFC_CNT_ZERO
            && ovf_q == $past(ovf_q) + 16'h0001;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter wrap not tallied");
endmodule : rfc_channel
`default_nettype wire

// file: rtl/rfc_counter.sv
// reciprocal frequency counter for the meter timer
// assumes window_comparator_output and ref_clk_in are async pins, and
// that the 32768 Hz reference is far slower than core_clk
//
// How it works
// - three 16-bit channels: period, input, reference
// - input and reference counts captured together
// - second capture event starts the frequency calculation
// - overflows tallied; capture adds 65536 per wrap
// - reference clock is 32768 Hz
// - period value is twice the compare value
// - second and third period edges store captures
// - diff >= 4000 divides by period value
// - diff < 4000 divides by reference difference
`timescale 1ns/1ps
`default_nettype none
module rfc_counter
    import rfc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // measurement pins
    input wire logic window_comparator_output,
    input wire logic ref_clk_in,
    // configuration
    input wire logic start,
    input wire logic [RFC_CNT_W-1:0] period_compare_value,
    // results
    output logic compare_capture_event,
    output logic freq_valid,
    output logic [RFC_FRQ_W-1:0] freq_q,
    output logic busy
);
    // ************************************************************
    // input synchronisers and edge detect
    // ************************************************************
    logic [1:0] win_sync_q;
    logic [1:0] ref_sync_q;
    logic win_prev_q;
    logic ref_prev_q;
    logic win_rise;
    logic ref_rise;

    // two flops per pin; only the second flop feeds logic
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            win_sync_q <= 2'h0;
            ref_sync_q <= 2'h0;
            win_prev_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            win_sync_q <= {win_sync_q[0], window_comparator_output};
            ref_sync_q <= {ref_sync_q[0], ref_clk_in};
            win_prev_q <= win_sync_q[1];
            ref_prev_q <= ref_sync_q[1];
        end
    end

    assign win_rise = win_sync_q[1] && !win_prev_q;
    assign ref_rise = ref_sync_q[1] && !ref_prev_q;

    // ************************************************************
    // channel 0: period generator
    // ************************************************************
    logic [RFC_CNT_W-1:0] per_cnt_q;
    logic per_sig_q;
    logic period_rise;
    logic per_match;
    logic [1:0] edge_cnt_q;
    logic run_q;

    // period counts reference ticks; the signal toggles each match,
    // so one full period spans twice the compare value
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            per_cnt_q <= RFC_CNT_ZERO;
            per_sig_q <= 1'b0;
        end else if (!run_q) begin
            per_cnt_q <= RFC_CNT_ZERO;
            per_sig_q <= 1'b0;
        end else if (ref_rise) begin
            if (per_match) begin
                per_cnt_q <= RFC_CNT_ZERO;
                per_sig_q <= !per_sig_q;
            end else begin
                per_cnt_q <= per_cnt_q + 16'h0001;
            end
        end
    end

    // one compare shared by the toggle and the rise detect, so the two
    // can never disagree about which tick ends a half period
    assign per_match = per_cnt_q >= period_compare_value - 16'h0001;
    assign period_rise = run_q && ref_rise && !per_sig_q && per_match;

    // ************************************************************
    // channels 1 and 2: input edges and reference ticks
    // ************************************************************
    logic capture;
    logic [RFC_CUM_W-1:0] in_cum;
    logic [RFC_CUM_W-1:0] ref_cum;

    assign capture = period_rise;

    rfc_channel u_in_chan (
        .core_clk(core_clk),
        .resetn(resetn),
        .count_en(win_rise),
        .capture(capture),
        .cum_q(in_cum)
    );

    // reference is counted at the ref_clk_in rate, assumed to be 32768 Hz
    rfc_channel u_ref_chan (
        .core_clk(core_clk),
        .resetn(resetn),
        .count_en(ref_rise),
        .capture(capture),
        .cum_q(ref_cum)
    );

    // ************************************************************
    // period edge sequencing and stored captures
    // ************************************************************
    logic [RFC_CUM_W-1:0] in1_q;
    logic [RFC_CUM_W-1:0] ref1_q;
    logic [RFC_CUM_W-1:0] in2_q;
    logic [RFC_CUM_W-1:0] ref2_q;
    logic cap_d1_q;
    logic calc_go_q;

    // capture lands one cycle after the edge; store the cycle after
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 1'b0;
            edge_cnt_q <= 2'h0;
            cap_d1_q <= 1'b0;
            compare_capture_event <= 1'b0;
            calc_go_q <= 1'b0;
            in1_q <= '0;
            ref1_q <= '0;
            in2_q <= '0;
            ref2_q <= '0;
        end else begin
            cap_d1_q <= capture;
            compare_capture_event <= 1'b0;
            calc_go_q <= 1'b0;
            if (start) begin
                run_q <= 1'b1;
                edge_cnt_q <= RFC_EDGE_FIRST - 2'h1; // start is rise one
            end else if (cap_d1_q && run_q) begin
                if (edge_cnt_q == RFC_EDGE_FIRST - 2'h1) begin
                    in1_q <= in_cum;
                    ref1_q <= ref_cum;
                    edge_cnt_q <= RFC_EDGE_FIRST;
                    compare_capture_event <= 1'b1;
                end else if (edge_cnt_q == RFC_EDGE_FIRST) begin
                    in2_q <= in_cum;
                    ref2_q <= ref_cum;
                    edge_cnt_q <= RFC_EDGE_SECOND;
                    compare_capture_event <= 1'b1;
                    calc_go_q <= 1'b1;
                    run_q <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // frequency calculation: restoring divider
    // ************************************************************
    rfc_state_t state_q;
    logic [RFC_QUO_W-1:0] num_q;
    logic [RFC_QUO_W-1:0] rem_q;
    logic [RFC_CUM_W-1:0] den_q;
    logic [6:0] bit_q;
    logic [RFC_CUM_W-1:0] n_diff;
    logic [RFC_CUM_W-1:0] e_diff;
    logic [RFC_CUM_W-1:0] n_r;
    logic [RFC_QUO_W-1:0] rem_sh;

    // wrap-safe differences of cumulative captures
    function automatic logic [RFC_CUM_W-1:0] rfc_diff(
        input logic [RFC_CUM_W-1:0] a,
        input logic [RFC_CUM_W-1:0] b
    );
        rfc_diff = a - b;
    endfunction : rfc_diff

    assign n_diff = rfc_diff(in2_q, in1_q);
    assign e_diff = rfc_diff(ref2_q, ref1_q);
    assign n_r = {15'h0000, period_compare_value, 1'b0};
    assign rem_sh = {rem_q[RFC_QUO_W-2:0], num_q[RFC_QUO_W-1]};

    // iterative division trades latency for area: 64 divide steps, 66 cycles from calc_go_q to result
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= RFC_IDLE;
            num_q <= '0;
            rem_q <= '0;
            den_q <= '0;
            bit_q <= 7'h00;
            freq_q <= '0;
            freq_valid <= 1'b0;
            busy <= 1'b0;
        end else begin
            freq_valid <= 1'b0;
            case (state_q)
                RFC_IDLE: begin
                    if (calc_go_q) begin
                        num_q <= RFC_REF_FREQ * n_diff;
                        rem_q <= '0;
                        bit_q <= RFC_DIV_STEPS;
                        busy <= 1'b1;
                        state_q <= RFC_DIV;
                        if (n_diff >= RFC_THRESHOLD) begin
                            den_q <= n_r;
                        end else begin
                            den_q <= e_diff;
                        end
                    end
                end
                RFC_DIV: begin
                    num_q <= {num_q[RFC_QUO_W-2:0], 1'b0};
                    if (den_q != '0 && rem_sh >= {32'h0, den_q}) begin
                        rem_q <= rem_sh - {32'h0, den_q};
                        num_q[0] <= 1'b1;
                    end else begin
                        rem_q <= rem_sh;
                    end
                    bit_q <= bit_q - 7'h01;
                    if (bit_q == RFC_DIV_LAST) begin
                        state_q <= RFC_DONE;
                    end
                end
                RFC_DONE: begin
                    freq_q <= num_q[RFC_FRQ_W-1:0];
                    freq_valid <= 1'b1;
                    busy <= 1'b0;
                    state_q <= RFC_IDLE;
                end
                default: state_q <= RFC_IDLE;
            endcase
        end
    end

    property p_calc_start;
        @(posedge core_clk) disable iff (!resetn)
        calc_go_q |=> state_q == RFC_DIV;
    endproperty
    a_calc_start: assert property (p_calc_start)
        else $error("calculation did not start after capture");

    property p_result_bound;
        @(posedge core_clk) disable iff (!resetn)
        calc_go_q |-> ##[60:70] freq_valid;
    endproperty
    a_result_bound: assert property (p_result_bound)
        else $error("result not produced in time");

    property p_den_select_hi;
        @(posedge core_clk) disable iff (!resetn)
        (calc_go_q && n_diff >= RFC_THRESHOLD) |=> den_q == n_r;
    endproperty
    a_den_select_hi: assert property (p_den_select_hi)
        else $error("period denominator not chosen");

    property p_den_select_lo;
        @(posedge core_clk) disable iff (!resetn)
        (calc_go_q && n_diff < RFC_THRESHOLD) |=> den_q == $past(e_diff);
    endproperty
    a_den_select_lo: assert property (p_den_select_lo)
        else $error("reference denominator not chosen");

    property p_second_store;
        @(posedge core_clk) disable iff (!resetn)
        calc_go_q |-> in2_q == $past(in_cum) && ref2_q == $past(ref_cum);
    endproperty
    a_second_store: assert property (p_second_store)
        else $error("second capture pair not stored");

    property p_event_pulse;
        @(posedge core_clk) disable iff (!resetn)
        compare_capture_event |=> !compare_capture_event;
    endproperty
    a_event_pulse: assert property (p_event_pulse)
        else $error("capture event longer than a cycle");
endmodule : rfc_counter
`default_nettype wire

// file: rtl/rfc_pkg.sv
// constants and types for the reciprocal frequency counter
// assumes one timer clock domain and an asynchronous active-low reset
package rfc_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int RFC_CNT_W = 16;
    localparam int RFC_OVF_W = 16;
    localparam int RFC_CUM_W = 32;
    localparam int RFC_FRQ_W = 32;
    localparam int RFC_QUO_W = 64;
    // ************************************************************
    // timing and arithmetic constants
    // ************************************************************
    localparam int RFC_CORE_HZ = 250_000_000;
    localparam int RFC_REF_HZ = 32768;
    localparam logic [RFC_CUM_W-1:0] RFC_REF_FREQ = 32'h0000_8000;
    localparam logic [RFC_CUM_W-1:0] RFC_THRESHOLD = 32'h0000_0FA0;
    localparam logic [RFC_CNT_W-1:0] RFC_CNT_MAX = 16'hFFFF;
    localparam logic [RFC_CNT_W-1:0] RFC_CNT_ZERO = 16'h0000;
    localparam logic [1:0] RFC_EDGE_FIRST = 2'h2;
    localparam logic [1:0] RFC_EDGE_SECOND = 2'h3;
    // one divider step per quotient bit, last step ends the division
    localparam logic [6:0] RFC_DIV_STEPS = 7'h40;
    localparam logic [6:0] RFC_DIV_LAST = 7'h01;
    // ************************************************************
    // divider states
    // ************************************************************
    typedef enum logic [1:0] {RFC_IDLE, RFC_DIV, RFC_DONE} rfc_state_t;
endpackage : rfc_pkg

// file: verif/rfc_wave_model.sv
// far-side model: comparator square wave plus reference clock
// assumes core_clk is the timebase; pins change on falling edges
`timescale 1ns/1ps
`default_nettype none
module rfc_wave_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // half periods in core cycles
    input wire logic [15:0] ref_half,
    input wire logic [15:0] wave_half,
    input wire logic wave_on,
    // pins toward the counter
    output logic ref_clk_in,
    output logic window_comparator_output
);
    // ************************************************************
    // shared timebase
    // ************************************************************
    logic [31:0] tick_q;
    // reference is sped up to keep runs short; the arithmetic only
    // sees counts, so the result scales the same way
    // wave edges sit a quarter wave period away from reference edges, so
    // both pins resolve in a fixed order through identical syncs
    always @(negedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tick_q <= 32'h0000_0000;
            ref_clk_in <= 1'b0;
            window_comparator_output <= 1'b0;
        end else begin
            tick_q <= tick_q + 32'h0000_0001;
            if (tick_q % 32'(ref_half) == 32'h0000_0000) begin
                ref_clk_in <= !ref_clk_in;
            end
            if (!wave_on) begin
                window_comparator_output <= 1'b0; // idle low
            end else if (tick_q % 32'(wave_half) == 32'(wave_half >> 1)) begin
                window_comparator_output <= !window_comparator_output;
            end
        end
    end
endmodule : rfc_wave_model
`default_nettype wire

// file: verif/test_reciprocal_frequency_counter.sv
// self-checking bench for the reciprocal frequency counter
// assumes the far-side model drives both measurement pins
`timescale 1ns/1ps
`default_nettype none
module test_reciprocal_frequency_counter
    import rfc_pkg::*;
();
    // ************************************************************
    // stimulus and checking
    // ************************************************************
    logic core_clk, resetn, start, wave_on;
    logic window_comparator_output, ref_clk_in;
    logic [15:0] ref_half, wave_half;
    logic [RFC_CNT_W-1:0] period_compare_value;
    logic compare_capture_event, freq_valid, busy;
    logic [RFC_FRQ_W-1:0] freq_q;
    int mismatches = 0;
    int samples_checked = 0;

    rfc_counter rfc_counter_i (.core_clk(core_clk), .resetn(resetn),
        .window_comparator_output(window_comparator_output),
        .ref_clk_in(ref_clk_in), .start(start),
        .period_compare_value(period_compare_value),
        .compare_capture_event(compare_capture_event),
        .freq_valid(freq_valid), .freq_q(freq_q), .busy(busy));
    rfc_wave_model rfc_wave_model_i (.core_clk(core_clk), .resetn(resetn),
        .ref_half(ref_half), .wave_half(wave_half), .wave_on(wave_on),
        .ref_clk_in(ref_clk_in),
        .window_comparator_output(window_comparator_output));

    // 250 MHz core clock
    always #2 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] want,
                         input string what);
        samples_checked++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: %s %h not %h", $time, what, seen,
                     want);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // one measurement; h must divide r so edge counts are exact
    task automatic measure(input int pcv, input int r, input int h,
                           input bit restart);
        int n_ev, ev_cyc, fin_cyc, din;
        logic [31:0] want;
        n_ev = 0;
        ev_cyc = 0;
        fin_cyc = -1;
        din = 2 * pcv * r / h;
        want = 32'(32768 * din / (2 * pcv));
        @(negedge core_clk);
        ref_half = 16'(r);
        wave_half = 16'(h);
        wave_on = 1'b1;
        period_compare_value = 16'(pcv);
        repeat (4) @(negedge core_clk);
        start = 1'b1;
        for (int cyc = 1; cyc < 90000 && fin_cyc < 0; cyc++) begin
            @(negedge core_clk);
            if (compare_capture_event === 1'b1) begin
                n_ev++;
                ev_cyc = cyc;
            end
            // restart lands right on the first capture
            start = (restart && n_ev == 1 && ev_cyc == cyc) ? 1'b1 : 1'b0;
            if (start) begin
                restart = 1'b0;
                n_ev = 0;
            end
            if (n_ev == 2 && cyc == ev_cyc + 10) begin
                check(32'(busy), 32'h1, "busy");
            end
            if (freq_valid === 1'b1) begin
                fin_cyc = cyc;
            end
        end
        check(32'(fin_cyc >= 0), 32'h1, "result seen");
        check(32'(n_ev), 32'h2, "captures");
        check(32'(fin_cyc - ev_cyc), 32'h0000_0042, "latency");
        check(freq_q, want, "frequency");
        repeat (5) @(negedge core_clk);
        check(freq_q, want, "held");
    endtask : measure

    task automatic test_after_reset();
        check(32'(freq_valid), 32'h0, "valid");
        check(32'(compare_capture_event), 32'h0, "event");
        check(freq_q, 32'h0000_0000, "freq");
        $display("done after_reset");
    endtask : test_after_reset

    task automatic test_slow_input();
        measure(3, 20, 10, 1'b0);
        $display("done slow_input");
    endtask : test_slow_input

    task automatic test_min_period();
        measure(1, 20, 20, 1'b0);
        $display("done min_period");
    endtask : test_min_period

    task automatic test_restart();
        measure(2, 20, 10, 1'b1);
        $display("done restart");
    endtask : test_restart

    task automatic test_mid_reset();
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        repeat (50) @(negedge core_clk);
        resetn = 1'b0;
        @(negedge core_clk);
        check(32'(busy), 32'h0, "busy in reset");
        check(freq_q, 32'h0000_0000, "freq in reset");
        resetn = 1'b1;
        measure(1, 20, 10, 1'b0);
        $display("done mid_reset");
    endtask : test_mid_reset

    task automatic test_fast_input();
        measure(2, 4000, 4, 1'b0);
        $display("done fast_input");
    endtask : test_fast_input

    // hang guard: whole run is well under this span
    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end

    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        start = 1'b0;
        wave_on = 1'b0;
        ref_half = 16'h0014;
        wave_half = 16'h000A;
        period_compare_value = 16'h0001;
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        test_after_reset();
        test_slow_input();
        test_min_period();
        test_restart();
        test_mid_reset();
        test_fast_input();
        stop_test();
    end
endmodule : test_reciprocal_frequency_counter
`default_nettype wire
